// File: hw/aodf_top.sv
/*
  Analog output DAC formatter: two 8-bit output channels with source select,
  window shift, offset, overflow guard, lowpass and fine-signal scaling,
  a register port for software and a two-entry buffer toward the converter.
  Assumes source samples and the converter handshake share I_CLK.
*/
// Summary of operation
// R1: Channel a selects source 0..530, default 34
// R2: Channel b selects independently, default 35
// R3: Shift 0..47 picks the 8-bit window
// R4: Signed offset -128..127 added to code
// R5: Guard on: excess bits force full scale
// R6: Guard off: excess bits dropped, code wraps
// R7: Lowpass 0..1000 ms, zero bypasses it
// R8: Speed source scaled by speed percentage
// R9: Utilization source scaled by utilization percentage
// R10: Torque source, twice rated, scaled by percentage
// R11: Torque source output keeps its sign
// R12: Reserved segment and memory offset stored
// R13: Final code is two's complement
`timescale 1ns/1ps
module aodf_top #(
  parameter int P_UNIT_CYCLES = aodf_pkg::UNIT_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic I_SIG_VALID,
  input wire aodf_pkg::aodf_sample_t I_SIG,
  output logic O_SIG_READY,
  output logic O_DAC_VALID,
  output aodf_pkg::aodf_dac_word_t O_DAC_DATA,
  input wire logic I_DAC_READY
);
  localparam int NC = aodf_pkg::NUM_CHAN;

  // Clamp helpers shared by several register writes
  // Unsigned clamp stores the limit itself when a write goes past it
  function automatic logic [15:0] clamp_u(input logic [31:0] v, input logic [15:0] max);
    clamp_u = (v > {16'h0000, max}) ? max : v[15:0];
  endfunction

  // Signed saturation of the nine-bit sum back to one code byte
  function automatic logic signed [7:0] sat9(input logic signed [8:0] v);
    if (v > 9'sh07f) begin
      sat9 = aodf_pkg::CODE_POS_FS;
    end else if (v < -9'sh080) begin
      sat9 = aodf_pkg::CODE_NEG_FS;
    end else begin
      sat9 = v[7:0];
    end
  endfunction

  // Base of a channel's register window; both channels share one field layout
  function automatic logic [7:0] chan_base(input int ch);
    chan_base = (ch == 0) ? aodf_pkg::OFS_CHAN_A : aodf_pkg::OFS_CHAN_B;
  endfunction

  logic signed [11:0] speed_output_scale_q;
  logic signed [11:0] utilization_output_scale_q;
  logic signed [11:0] torque_output_scale_q;
  logic [9:0] source_select_q [NC];
  logic [5:0] window_shift_q [NC];
  logic signed [7:0] output_offset_q [NC];
  logic overflow_guard_q [NC];
  logic [15:0] smoothing_time_q [NC];
  logic [1:0] segment_sel_q [NC];
  logic [19:0] mem_offset_q [NC];
  aodf_pkg::aodf_sample_t sample_q [NC];
  logic signed [7:0] code_q [NC];
  logic signed [7:0] smooth_y [NC];
  logic [31:0] rdata_q;

  // Address decode
  logic wr_speed, wr_util, wr_torque;
  logic [NC-1:0] chan_hit;
  logic [7:0] chan_field [NC];
  logic signed [31:0] wsig;
  logic signed [11:0] scale_w;
  assign wr_speed = I_WR && I_ADDR == aodf_pkg::OFS_SPEED_SCALE;
  assign wr_util = I_WR && I_ADDR == aodf_pkg::OFS_UTIL_SCALE;
  assign wr_torque = I_WR && I_ADDR == aodf_pkg::OFS_TORQUE_SCALE;
  // Channel hits and field offsets are decoded per channel below
  assign wsig = I_WDATA;
  // Out of range percentages clamp rather than wrap, so a typo cannot flip sign
  assign scale_w = (wsig > 32'sd2000) ? aodf_pkg::SCALE_MAX :
                   (wsig < -32'sd2000) ? aodf_pkg::SCALE_MIN : wsig[11:0];

  // Global scale registers
  // Scales are signed tenths of a percent; a negative one inverts the fine output
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      speed_output_scale_q <= aodf_pkg::SCALE_RST;
      utilization_output_scale_q <= aodf_pkg::SCALE_RST;
      torque_output_scale_q <= aodf_pkg::SCALE_RST;
    end else begin
      if (wr_speed) speed_output_scale_q <= scale_w; // R8
      if (wr_util) utilization_output_scale_q <= scale_w; // R9
      if (wr_torque) torque_output_scale_q <= scale_w; // R10
    end
  end

  // Per channel datapath
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_chan
      logic wr_ch;
      logic signed [47:0] val;
      logic signed [47:0] shifted;
      logic upper_clean;
      logic signed [7:0] win_code;
      logic is_fine;
      logic signed [11:0] fine_scale;
      logic signed [55:0] fine_prod;
      logic signed [55:0] fine_raw;
      logic signed [55:0] fine_gain;
      logic signed [13:0] fine_val;
      logic fine_clean;
      logic signed [7:0] fine_code;
      logic signed [7:0] base_code;
      logic signed [8:0] sum;
      logic signed [7:0] final_code;
      logic signed [31:0] off_w;

      // Field offset inside this channel's window; addresses past the last field miss
      assign chan_field[c] = I_ADDR - chan_base(c);
      assign chan_hit[c] = chan_field[c] <= aodf_pkg::OFS_MEMOFS;
      assign wr_ch = I_WR && chan_hit[c];
      assign off_w = I_WDATA;

      // Setting registers of this channel; writes clamp to the legal range
      // Guard keeps bit 0 only; reserved selectors are stored and read back, nothing more
      always_ff @(posedge I_CLK) begin
        if (I_RST) begin
          source_select_q[c] <= (c == 0) ? aodf_pkg::SRC_RST_A : aodf_pkg::SRC_RST_B; // R1 R2
          window_shift_q[c] <= 6'h00;
          output_offset_q[c] <= 8'sh00;
          overflow_guard_q[c] <= aodf_pkg::GUARD_RST;
          smoothing_time_q[c] <= 16'h0000;
          segment_sel_q[c] <= 2'h0;
          mem_offset_q[c] <= 20'h00000;
        end else if (wr_ch) begin
          unique case (chan_field[c])
            aodf_pkg::OFS_SOURCE: source_select_q[c] <= 10'(clamp_u(I_WDATA, 16'(aodf_pkg::SRC_MAX))); // R1 R2
            aodf_pkg::OFS_SHIFT: window_shift_q[c] <= 6'(clamp_u(I_WDATA, 16'(aodf_pkg::SHIFT_MAX))); // R3
            aodf_pkg::OFS_OFFSET: output_offset_q[c] <= (off_w > 32'sd127) ? 8'sh7f :
                                  (off_w < -32'sd128) ? 8'sh80 : off_w[7:0]; // R4
            aodf_pkg::OFS_GUARD: overflow_guard_q[c] <= I_WDATA[0];
            aodf_pkg::OFS_SMOOTH: smoothing_time_q[c] <= clamp_u(I_WDATA, aodf_pkg::SMOOTH_MAX); // R7
            aodf_pkg::OFS_SEGMENT: segment_sel_q[c] <= 2'(clamp_u(I_WDATA, 16'(aodf_pkg::SEGMENT_MAX))); // R12
            aodf_pkg::OFS_MEMOFS: mem_offset_q[c] <= (I_WDATA > 32'(aodf_pkg::MEMOFS_MAX)) ?
                                  aodf_pkg::MEMOFS_MAX : I_WDATA[19:0]; // R12
            default: ;
          endcase
        end
      end

      // Capture the selected signal; a stalled buffer holds back the source
      // Samples for other numbers pass by; each channel keeps its last match
      always_ff @(posedge I_CLK) begin
        if (I_RST) begin
          sample_q[c] <= '0;
        end else if (I_SIG_VALID && O_SIG_READY && I_SIG.num == source_select_q[c]) begin
          sample_q[c] <= I_SIG; // R1 R2
        end
      end

      // Window path: arithmetic shift keeps the sign of the wide word
      // Guard compares every bit above bit 7 with the sign, not just the next one
      assign val = sample_q[c].data;
      assign shifted = val >>> window_shift_q[c]; // R3
      assign upper_clean = (shifted[47:7] == '0) || (shifted[47:7] == '1);
      assign win_code = (overflow_guard_q[c] && !upper_clean) ?
                        (val[47] ? aodf_pkg::CODE_NEG_FS : aodf_pkg::CODE_POS_FS) : // R5
                        shifted[7:0]; // R6

      // Fine-normalized path bypasses the shift and uses its own percentage
      assign is_fine = source_select_q[c] == aodf_pkg::SRC_SPEED ||
                       source_select_q[c] == aodf_pkg::SRC_UTIL ||
                       source_select_q[c] == aodf_pkg::SRC_TORQUE;
      assign fine_scale = (source_select_q[c] == aodf_pkg::SRC_SPEED) ? speed_output_scale_q : // R8
                          (source_select_q[c] == aodf_pkg::SRC_UTIL) ? utilization_output_scale_q : // R9
                          torque_output_scale_q; // R10
      // Low 24 bits taken as signed, so negative torque gives a negative code
      assign fine_raw = 56'($signed(val[23:0])); // R11
      // Every factor is widened first; a narrower product would drop the top bits
      assign fine_gain = 56'(fine_scale) * 56'($signed({1'b0, aodf_pkg::FINE_RECIP}));
      assign fine_prod = fine_raw * fine_gain; // R11
      assign fine_val = 14'(fine_prod >>> aodf_pkg::FINE_SHIFT);
      assign fine_clean = (fine_val[13:7] == '0) || (fine_val[13:7] == '1);
      assign fine_code = (overflow_guard_q[c] && !fine_clean) ?
                         (fine_val[13] ? aodf_pkg::CODE_NEG_FS : aodf_pkg::CODE_POS_FS) : // R5
                         fine_val[7:0]; // R6

      // Offset, then saturate under guard or wrap without it
      assign base_code = is_fine ? fine_code : win_code;
      assign sum = {base_code[7], base_code} + {output_offset_q[c][7], output_offset_q[c]}; // R4
      assign final_code = overflow_guard_q[c] ? sat9(sum) : sum[7:0]; // R5 R6

      // Registered code, two's complement toward the converter
      // The register also cuts the long multiply path ahead of the filter
      always_ff @(posedge I_CLK) begin
        if (I_RST) begin
          code_q[c] <= 8'sh00;
        end else begin
          code_q[c] <= final_code; // R13
        end
      end

      // Each channel filters its own code; a zero time constant passes it through
      aodf_lowpass #(
        .P_UNIT_CYCLES(P_UNIT_CYCLES)
      ) u_lowpass (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_x(code_q[c]),
        .i_tau(smoothing_time_q[c]),
        .o_y(smooth_y[c])
      );
    end
  endgenerate

  // Two-entry buffer toward the converter
  // While both entries wait, stored words stay unchanged and the source is held back;
  // the latest code is queued once the converter frees an entry
  aodf_pkg::aodf_dac_word_t buf_mem_q [2];
  aodf_pkg::aodf_dac_word_t new_word;
  aodf_pkg::aodf_dac_word_t last_q;
  logic [1:0] cnt_q;
  logic wr_ptr_q, rd_ptr_q;
  logic buf_in_ready, push, pop;

  assign new_word.chan_a = smooth_y[0];
  assign new_word.chan_b = smooth_y[1];
  assign buf_in_ready = cnt_q != 2'h2;
  // Only changed words are queued; when full the change waits, never lost
  assign push = buf_in_ready && new_word != last_q;
  assign pop = O_DAC_VALID && I_DAC_READY;
  assign O_DAC_VALID = cnt_q != 2'h0;
  assign O_DAC_DATA = buf_mem_q[rd_ptr_q];
  // Source is held back only when no room is left for a changed word
  assign O_SIG_READY = buf_in_ready;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      buf_mem_q[0] <= '0;
      buf_mem_q[1] <= '0;
      last_q <= '0;
      cnt_q <= 2'h0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end else begin
      if (push) begin
        buf_mem_q[wr_ptr_q] <= new_word;
        last_q <= new_word;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end

  // Read mux; status shows both live codes and buffer state
  // Unmapped addresses and the gaps between channel fields read zero
  logic [31:0] rd_mux;
  logic [31:0] ch_rd [NC];
  generate
    for (c = 0; c < NC; c++) begin : g_rd
      always_comb begin
        ch_rd[c] = 32'h00000000;
        unique case (chan_field[c])
          aodf_pkg::OFS_SOURCE: ch_rd[c] = 32'(source_select_q[c]);
          aodf_pkg::OFS_SHIFT: ch_rd[c] = 32'(window_shift_q[c]);
          aodf_pkg::OFS_OFFSET: ch_rd[c] = 32'(output_offset_q[c]);
          aodf_pkg::OFS_GUARD: ch_rd[c] = 32'(overflow_guard_q[c]);
          aodf_pkg::OFS_SMOOTH: ch_rd[c] = 32'(smoothing_time_q[c]);
          aodf_pkg::OFS_SEGMENT: ch_rd[c] = 32'(segment_sel_q[c]);
          aodf_pkg::OFS_MEMOFS: ch_rd[c] = 32'(mem_offset_q[c]);
          default: ch_rd[c] = 32'h00000000;
        endcase
      end
    end
  endgenerate

  // Status word: buffer fill in bits 17:16, live filtered codes below
  assign rd_mux = (I_ADDR == aodf_pkg::OFS_SPEED_SCALE) ? 32'(speed_output_scale_q) :
                  (I_ADDR == aodf_pkg::OFS_UTIL_SCALE) ? 32'(utilization_output_scale_q) :
                  (I_ADDR == aodf_pkg::OFS_TORQUE_SCALE) ? 32'(torque_output_scale_q) :
                  (I_ADDR == aodf_pkg::OFS_STATUS) ? {14'h0000, cnt_q, new_word} :
                  chan_hit[0] ? ch_rd[0] :
                  chan_hit[1] ? ch_rd[1] : 32'h00000000;

  // Read data stands only in the cycle after the strobe
  // Zero outside that cycle keeps a shared read bus free of stale values
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= I_RD ? rd_mux : 32'h00000000;
    end
  end
  assign O_RDATA = rdata_q;
endmodule

// File: hw/aodf_pkg.sv
/*
  Package of the analog output DAC formatter: register offsets, field widths,
  reset values, limits, timing counts and the structs carried between blocks.
  Assumes nothing beyond a SystemVerilog compiler; it holds no logic.
*/
package aodf_pkg;
  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CHAN = 2;

  // Global registers (byte addresses)
  localparam logic [7:0] OFS_SPEED_SCALE = 8'h00;
  localparam logic [7:0] OFS_UTIL_SCALE = 8'h04;
  localparam logic [7:0] OFS_TORQUE_SCALE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  // Channel blocks: base plus field offset, channel a then channel b
  localparam logic [7:0] OFS_CHAN_A = 8'h10;
  localparam logic [7:0] OFS_CHAN_B = 8'h30;
  localparam logic [7:0] OFS_SOURCE = 8'h00;
  localparam logic [7:0] OFS_SHIFT = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_GUARD = 8'h0c;
  localparam logic [7:0] OFS_SMOOTH = 8'h10;
  localparam logic [7:0] OFS_SEGMENT = 8'h14;
  localparam logic [7:0] OFS_MEMOFS = 8'h18;

  // Field widths and limits
  localparam int SRC_W = 10;
  localparam logic [9:0] SRC_MAX = 10'h212;          // 530
  localparam logic [9:0] SRC_RST_A = 10'h022;        // 34
  localparam logic [9:0] SRC_RST_B = 10'h023;        // 35
  localparam logic [9:0] SRC_SPEED = 10'h022;        // Fine speed, 34
  localparam logic [9:0] SRC_UTIL = 10'h023;         // Fine utilization, 35
  localparam logic [9:0] SRC_TORQUE = 10'h024;       // Fine torque, 36
  localparam logic [5:0] SHIFT_MAX = 6'h2f;          // 47
  localparam logic [15:0] SMOOTH_MAX = 16'h2710;     // 1000.0 ms in 0.1 ms units
  localparam logic [1:0] SEGMENT_MAX = 2'h2;
  localparam logic [19:0] MEMOFS_MAX = 20'hfffff;
  localparam logic signed [11:0] SCALE_MAX = 12'sh7d0;  // +200.0 % in 0.1 %
  localparam logic signed [11:0] SCALE_MIN = -12'sh7d0; // -200.0 %
  localparam logic signed [11:0] SCALE_RST = 12'sh3e8;  // 100.0 %
  localparam logic GUARD_RST = 1'b1;

  // Fine signals: full reference (max speed, 100 % load, 2x rated torque) = 2^22
  localparam int FINE_W = 24;
  // 127 / 1000 in units of 2^-20, then the 2^22 reference: total shift 42
  localparam logic [17:0] FINE_RECIP = 18'h20831;
  localparam int FINE_SHIFT = 42;
  localparam logic signed [7:0] CODE_POS_FS = 8'sh7f;
  localparam logic signed [7:0] CODE_NEG_FS = 8'sh80;

  // Lowpass timing: setting unit 0.1 ms, 64 Euler steps per time constant
  localparam int CLK_PERIOD_PS = 20000;
  localparam int SMOOTH_UNIT_PS = 100000000;
  localparam int UNIT_CYCLES = SMOOTH_UNIT_PS / CLK_PERIOD_PS;
  localparam int LP_SHIFT = 6;
  localparam int LP_FRAC = 16;

  // Converter word and incoming source sample
  typedef struct packed {
    logic signed [7:0] chan_b;
    logic signed [7:0] chan_a;
  } aodf_dac_word_t;

  typedef struct packed {
    logic [9:0] num;
    logic signed [47:0] data;
  } aodf_sample_t;
endpackage

// File: hw/aodf_lowpass.sv
/*
  First order lowpass for one 8-bit output code.
  Assumes a free running clock and a time constant setting that changes
  rarely; a change takes effect at the next step.
*/
`timescale 1ns/1ps
module aodf_lowpass #(
  parameter int P_UNIT_CYCLES = aodf_pkg::UNIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic signed [7:0] i_x,
  input wire logic [15:0] i_tau,
  output logic signed [7:0] o_y
);
  localparam int STEP_PER_UNIT = P_UNIT_CYCLES >> aodf_pkg::LP_SHIFT;
  localparam logic [7:0] STEP_W = 8'(STEP_PER_UNIT);

  logic signed [23:0] acc_q;
  logic signed [23:0] acc_d;
  logic [23:0] cnt_q;
  logic [23:0] interval;
  logic signed [23:0] target;
  logic signed [24:0] rounded;
  logic signed [24:0] diff;
  logic step;

  // Step spacing is tau/64, so 64 steps of 1/64 make one time constant
  assign interval = 24'(i_tau) * 24'(STEP_W);
  assign step = (cnt_q + 24'h000001 >= interval);
  assign target = {i_x, 16'h0000};
  // Difference taken one bit wider so a full swing from +127 to -128 cannot wrap
  assign diff = 25'(target) - 25'(acc_q);
  assign acc_d = (i_tau == 16'h0000) ? target : // R7
                 acc_q + 24'(diff >>> aodf_pkg::LP_SHIFT);

  // Accumulator holds 8.16 fixed point; bypassed when tau is zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_q <= 24'sh000000;
      cnt_q <= 24'h000000;
    end else begin
      cnt_q <= step ? 24'h000000 : cnt_q + 24'h000001;
      if (step || i_tau == 16'h0000) begin
        acc_q <= acc_d; // R7
      end
    end
  end

  // Round to nearest so the floor bias of the shift cannot leave it one low
  assign rounded = {acc_q[23], acc_q} + 25'sh0008000;
  assign o_y = (rounded[24] != rounded[23]) ? aodf_pkg::CODE_POS_FS : rounded[23:16];
endmodule

// File: testbench/aodf_checker.sv
/*
  Port assertions for the analog output formatter.
  Assumes binding to aodf_top; sees only its ports, one clock domain.
*/
`timescale 1ns/1ps
module aodf_checker (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [31:0] O_RDATA,
  input wire logic I_SIG_VALID,
  input wire aodf_pkg::aodf_sample_t I_SIG,
  input wire logic O_SIG_READY,
  input wire logic O_DAC_VALID,
  input wire aodf_pkg::aodf_dac_word_t O_DAC_DATA,
  input wire logic I_DAC_READY
);
  // Channel field decode; folding bit 5 maps channel b fields 0x30..0x3c onto channel a
  wire logic [7:0] fld = I_ADDR & 8'hdf;
  wire logic rd_seg = I_RD && (I_ADDR == 8'h24 || I_ADDR == 8'h44);

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  // Outputs come out of reset idle
  reset_values_a: assert property ($fell(I_RST) |-> !O_DAC_VALID && O_SIG_READY && O_RDATA == 32'h0)
    else $error("outputs not idle after reset");
  // Read data stands only in the cycle after a read
  rdata_idle_a: assert property (!I_RD |=> O_RDATA == 32'h0)
    else $error("read data outside read slot");
  // A stalled word is held unchanged
  dac_hold_a: assert property (O_DAC_VALID && !I_DAC_READY |=> O_DAC_VALID && $stable(O_DAC_DATA))
    else $error("converter word changed while stalled");
  // Input is refused only while words wait
  full_stall_a: assert property (!O_SIG_READY |-> O_DAC_VALID)
    else $error("sample refused with empty buffer");
  // Register reads stay within documented limits
  src_range_a: assert property (I_RD && fld == 8'h10 |=> O_RDATA <= 32'h212)
    else $error("source select above limit");
  shift_range_a: assert property (I_RD && fld == 8'h14 |=> O_RDATA <= 32'h2f)
    else $error("shift above limit");
  offset_range_a: assert property (I_RD && fld == 8'h18 |=> O_RDATA >= 32'hffffff80 || O_RDATA <= 32'h7f)
    else $error("offset outside signed byte");
  guard_range_a: assert property (I_RD && fld == 8'h1c |=> O_RDATA <= 32'h1)
    else $error("guard wider than one bit");
  seg_range_a: assert property (rd_seg |=> O_RDATA <= 32'h2)
    else $error("segment above limit");
endmodule

// File: testbench/aodf_dac_model.sv
/*
  Converter model: accepts words under valid/ready and logs them in order.
  Assumes the formatter's clock; i_stall from the bench withdraws ready.
*/
`timescale 1ns/1ps
module aodf_dac_model (
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire aodf_pkg::aodf_dac_word_t i_data,
  output logic o_ready
);
  aodf_pkg::aodf_dac_word_t hist_q [0:255];
  int count_q = 0;

  // Ready drops only on command, so slow answers are under bench control
  assign o_ready = !i_stall;

  // Log each accepted code pair; the log wraps after 256 words
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      hist_q[count_q[7:0]] <= i_data;
      count_q <= count_q + 1;
    end
  end
endmodule

// File: testbench/tb_top.sv
/*
  Self-checking bench for the analog output formatter.
  Assumes the design package and the converter model; lowpass unit shortened.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic sig_valid = 1'b0;
  logic stall = 1'b0;
  aodf_pkg::aodf_sample_t sig = '0;
  aodf_pkg::aodf_dac_word_t dac_data;
  logic [31:0] o_rdata;
  logic o_sig_ready, dac_valid, dac_ready;
  int failures = 0;
  int comparisons = 0;
  int seen = 0;
  int cycles = 0;

  aodf_top #(.P_UNIT_CYCLES(64)) aodf_top_i (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(o_rdata), .I_SIG_VALID(sig_valid), .I_SIG(sig),
    .O_SIG_READY(o_sig_ready), .O_DAC_VALID(dac_valid), .O_DAC_DATA(dac_data), .I_DAC_READY(dac_ready));
  aodf_dac_model dac_i (.i_clk(clk), .i_stall(stall), .i_valid(dac_valid), .i_data(dac_data), .o_ready(dac_ready));

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cut a hang short; the run needs well under 20000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus cycles wait an edge first so no strobe is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(o_rdata, e);
  endtask

  // Sample handshake; released data is inverted so stale values cannot pass
  task automatic send(input logic [9:0] n, input logic signed [47:0] d);
    @(posedge clk);
    sig_valid <= 1'b1;
    sig.num <= n;
    sig.data <= d;
    @(negedge clk);
    while (!o_sig_ready) @(negedge clk);
    @(posedge clk);
    sig_valid <= 1'b0;
    sig.data <= ~d;
  endtask

  task automatic expw(input logic [15:0] w);
    for (int k = 0; k < 2000 && dac_i.count_q <= seen; k++) @(negedge clk);
    chk({16'h0, dac_i.hist_q[seen[7:0]]}, {16'h0, w});
    seen++;
  endtask

  // Words pushed by configuration writes are skipped before each sample
  task automatic xfer(input logic [9:0] n, input logic signed [47:0] d, input logic [15:0] w);
    repeat (8) @(negedge clk);
    seen = dac_i.count_q;
    send(n, d);
    expw(w);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h3e8);
    rd(8'h04, 32'h3e8);
    rd(8'h08, 32'h3e8);
    rd(8'h10, 32'h22);
    rd(8'h30, 32'h23);
    rd(8'h18, 32'h0);
    rd(8'h1c, 32'h1);
    rd(8'h3c, 32'h1);
    rd(8'h20, 32'h0);
    rd(8'h44, 32'h0);
    rd(8'h48, 32'h0);
    wr(8'h10, 32'h3ff);
    rd(8'h10, 32'h212);
    wr(8'h34, 32'h3f);
    rd(8'h34, 32'h2f);
    wr(8'h38, 32'h80);
    rd(8'h38, 32'h7f);
    wr(8'h18, 32'hffffff00);
    rd(8'h18, 32'hffffff80);
    wr(8'h24, 32'h3);
    rd(8'h24, 32'h2);
    wr(8'h28, 32'h1fffff);
    rd(8'h28, 32'hfffff);
    wr(8'h20, 32'hffff);
    rd(8'h20, 32'h2710);
    wr(8'h00, 32'h1000);
    rd(8'h00, 32'h7d0);
    wr(8'hfc, 32'h5);
    rd(8'hfc, 32'h0);
    wr(8'h00, 32'h3e8);
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h38, 32'h0);
    wr(8'h34, 32'h0);
    wr(8'h10, 32'h64);
    wr(8'h30, 32'h65);
    xfer(10'h64, 48'sh40, 16'h0040);
    xfer(10'h65, -48'sh10, 16'hf040);
    wr(8'h14, 32'h4);
    xfer(10'h64, 48'sh350, 16'hf035);
    xfer(10'h64, 48'sh1000, 16'hf07f);
    xfer(10'h64, -48'sh1000, 16'hf080);
    wr(8'h1c, 32'h0);
    xfer(10'h64, 48'sh1c50, 16'hf0c5);
    wr(8'h18, 32'h10);
    xfer(10'h64, 48'sh7a0, 16'hf08a);
    wr(8'h1c, 32'h1);
    xfer(10'h64, 48'sh3f0, 16'hf04f);
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h10, 32'h22);
    wr(8'h30, 32'h23);
    wr(8'h04, 32'h1f4);
    // Channel b now reads its old raw -16 through the fine path, which floors to -1
    xfer(10'h22, 48'sh200000, 16'hff3f);
    xfer(10'h23, 48'sh400000, 16'h3f3f);
    wr(8'h10, 32'h24);
    xfer(10'h24, -48'sh400000, 16'h3f81);
    // Converter stalls while two words queue up
    wr(8'h10, 32'h64);
    repeat (8) @(negedge clk);
    seen = dac_i.count_q;
    @(posedge clk);
    stall <= 1'b1;
    send(10'h64, 48'sh11);
    send(10'h64, 48'sh22);
    repeat (8) @(negedge clk);
    chk({31'h0, o_sig_ready}, 32'h0);
    chk({16'h0, dac_data}, 32'h3f11);
    @(posedge clk);
    stall <= 1'b0;
    expw(16'h3f11);
    expw(16'h3f22);
    // Smoothed step approaches its target gradually
    wr(8'h20, 32'h2);
    xfer(10'h64, 48'sh60, 16'h3f23);
    repeat (3000) @(negedge clk);
    chk({16'h0, dac_i.hist_q[8'(dac_i.count_q - 1)]}, 32'h3f60);
    summarize();
  end
endmodule

bind aodf_top aodf_checker aodf_checker_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SIG_VALID(I_SIG_VALID), .I_SIG(I_SIG),
  .O_SIG_READY(O_SIG_READY), .O_DAC_VALID(O_DAC_VALID), .O_DAC_DATA(O_DAC_DATA), .I_DAC_READY(I_DAC_READY));
